// ---- hw/pafm_pkg.sv ----
// package for the port alternate-function multiplexer
package pafm_pkg;

    // register word offsets on the plain register port
    localparam logic [3:0] PAFM_OFS_A_DIR = 4'h0;
    localparam logic [3:0] PAFM_OFS_A_ENABLE = 4'h1;
    localparam logic [3:0] PAFM_OFS_B_DIR = 4'h2;
    localparam logic [3:0] PAFM_OFS_B_ENABLE = 4'h3;
    localparam logic [3:0] PAFM_OFS_B_SET_ONE = 4'h4;
    localparam logic [3:0] PAFM_OFS_B_SET_TWO = 4'h5;
    localparam logic [3:0] PAFM_OFS_C_DIR = 4'h6;
    localparam logic [3:0] PAFM_OFS_C_ENABLE = 4'h7;
    localparam logic [3:0] PAFM_OFS_C_SET_ONE = 4'h8;
    localparam logic [3:0] PAFM_OFS_C_SET_TWO = 4'h9;
    localparam logic [3:0] PAFM_OFS_STATUS = 4'hA;

    // reset values: direction all inputs, no alternate functions
    localparam logic [7:0] PAFM_RST_DIR = 8'hFF;
    localparam logic [7:0] PAFM_RST_ZERO = 8'h00;

    // port b pin three choice when set-one bit is clear
    localparam int PAFM_CLOCK_PIN = 3;
    // port c pin three choice when set-one bit is clear
    localparam int PAFM_COMPARATOR_PIN = 3;

    // per-port configuration bundle
    typedef struct packed {
        logic [7:0] dir;      // 1 = input, as in general-purpose mode
        logic [7:0] enable;   // alternate-function enable
        logic [7:0] set_one;  // function_set_one_select
        logic [7:0] set_two;  // function_set_two_select, held only
    } pafm_port_cfg_type;

    // per-port pin-side result
    typedef struct packed {
        logic [7:0] alt;      // pin in alternate-function use
        logic [7:0] oe;       // output driver enable
        logic [7:0] out;      // value toward pin
    } pafm_pin_type;

endpackage : pafm_pkg

// ---- hw/pafm_mux.sv ----
// alternate-function multiplexer for ports a, b and c
//
// Functional notes
// - port a has no function-set select registers
// - port a enable alone connects its function
// - port a fixed per-pin peripheral routing
// - port b set-one high gives analog roles
// - port b pin3 clock or analog; 6,7 reserved
// - set-two registers stored but ignored
// - set-one acts only while enable is set
// - port c pins0-2 analog input plus led
// - port c led drive; pin3 low comparator
// - alternate pins take direction from peripheral
// - crystal enable overrides port a pins 0,1
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module pafm_mux
    import pafm_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // general-purpose output data per port
    input wire logic [7:0] GPIO_OUT_A,
    input wire logic [7:0] GPIO_OUT_B,
    input wire logic [7:0] GPIO_OUT_C,
    // crystal oscillator enable from oscillator control
    input wire logic XTAL_ENABLE,
    // peripheral drive, port a side (same clock domain)
    input wire logic TIMER_ZERO_IN_OR_COMPLEMENT_OUT,
    input wire logic TIMER_ZERO_IN_OR_COMPLEMENT_OE,
    input wire logic TIMER_ZERO_OUTPUT,
    input wire logic SERIAL_DRIVER_ENABLE,
    input wire logic SERIAL_INFRARED_TRANSMIT,
    input wire logic TIMER_ONE_IN_OR_COMPLEMENT_OUT,
    input wire logic TIMER_ONE_IN_OR_COMPLEMENT_OE,
    input wire logic TIMER_ONE_OUTPUT,
    // comparator result and led drive
    input wire logic COMPARATOR_RESULT_OUTPUT,
    input wire logic [7:0] LED_DRIVE_ON,
    // pin levels from pads, asynchronous
    input wire logic [7:0] PIN_IN_A,
    input wire logic [7:0] PIN_IN_B,
    // pin-side drive
    output logic [7:0] PIN_OUT_A,
    output logic [7:0] PIN_OE_A,
    output logic [7:0] PIN_OUT_B,
    output logic [7:0] PIN_OE_B,
    output logic [7:0] PIN_OUT_C,
    output logic [7:0] PIN_OE_C,
    // peripheral inputs recovered from pins
    output logic TIMER_ZERO_IN,
    output logic SERIAL_CLEAR_TO_SEND,
    output logic SERIAL_INFRARED_RECEIVE,
    output logic TIMER_ONE_IN,
    output logic EXTERNAL_CLOCK_INPUT,
    // analog switch closures, port c led mode and crystal pin claim
    output logic [7:0] ANALOG_CONNECT_B,
    output logic [7:0] ANALOG_CONNECT_C,
    output logic [7:0] LED_MODE_C,
    output logic XTAL_PINS_TAKEN
);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    //
    // one byte per index on the register port:
    //   0 a dir, 1 a enable
    //   2 b dir, 3 b enable, 4 b set-one, 5 b set-two
    //   6 c dir, 7 c enable, 8 c set-one, 9 c set-two
    //   10 status, read-only: bit 0 crystal on, bit 1 clock pin chosen
    // a direction bit of 1 means input, as in general-purpose mode;
    // writes to the status index or to an unmapped index are dropped

    logic [7:0] dir_a;       // port a direction
    logic [7:0] enable_a;    // port a alternate enable
    pafm_port_cfg_type cfg_b; // port b configuration
    pafm_port_cfg_type cfg_c; // port c configuration

    // write decode, one named wire per register
    // a write takes effect only on an edge with the clock enable high
    wire wr_a_dir = REG_WR && (REG_ADDR == PAFM_OFS_A_DIR);
    wire wr_a_en = REG_WR && (REG_ADDR == PAFM_OFS_A_ENABLE);
    wire wr_b_dir = REG_WR && (REG_ADDR == PAFM_OFS_B_DIR);
    wire wr_b_en = REG_WR && (REG_ADDR == PAFM_OFS_B_ENABLE);
    wire wr_b_s1 = REG_WR && (REG_ADDR == PAFM_OFS_B_SET_ONE);
    wire wr_b_s2 = REG_WR && (REG_ADDR == PAFM_OFS_B_SET_TWO);
    wire wr_c_dir = REG_WR && (REG_ADDR == PAFM_OFS_C_DIR);
    wire wr_c_en = REG_WR && (REG_ADDR == PAFM_OFS_C_ENABLE);
    wire wr_c_s1 = REG_WR && (REG_ADDR == PAFM_OFS_C_SET_ONE);
    wire wr_c_s2 = REG_WR && (REG_ADDR == PAFM_OFS_C_SET_TWO);

    // register writes; port a deliberately has no set-one/set-two storage
    // no port a sets
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dir_a <= PAFM_RST_DIR;
            enable_a <= PAFM_RST_ZERO;
            cfg_b <= {PAFM_RST_DIR, PAFM_RST_ZERO, PAFM_RST_ZERO, PAFM_RST_ZERO};
            cfg_c <= {PAFM_RST_DIR, PAFM_RST_ZERO, PAFM_RST_ZERO, PAFM_RST_ZERO};
        end else if (CE) begin
            if (wr_a_dir) dir_a <= REG_WDATA;
            if (wr_a_en) enable_a <= REG_WDATA;
            if (wr_b_dir) cfg_b.dir <= REG_WDATA;
            if (wr_b_en) cfg_b.enable <= REG_WDATA;
            if (wr_b_s1) cfg_b.set_one <= REG_WDATA;
            if (wr_b_s2) cfg_b.set_two <= REG_WDATA;
            if (wr_c_dir) cfg_c.dir <= REG_WDATA;
            if (wr_c_en) cfg_c.enable <= REG_WDATA;
            if (wr_c_s1) cfg_c.set_one <= REG_WDATA;
            if (wr_c_s2) cfg_c.set_two <= REG_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: two stages before any logic reads a pad
    // the pads move with no regard to CLK, so the first stage may go
    // metastable; only the second stage feeds routing. the price is a
    // three-edge lag from pad to peripheral input, fine for these pins

    logic [7:0] sync1_a; // first stage, read only by sync2_a
    logic [7:0] sync2_a;
    logic [7:0] sync1_b; // first stage, read only by sync2_b
    logic [7:0] sync2_b;

    // double-flop the pad levels
    // both stages reset low; nothing edge-sensitive reads them
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync1_a <= PAFM_RST_ZERO;
            sync2_a <= PAFM_RST_ZERO;
            sync1_b <= PAFM_RST_ZERO;
            sync2_b <= PAFM_RST_ZERO;
        end else if (CE) begin
            sync1_a <= PIN_IN_A;
            sync2_a <= sync1_a;
            sync1_b <= PIN_IN_B;
            sync2_b <= sync1_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port a routing
    //
    // each pin has exactly one peripheral, so the enable bit alone routes
    // it. pins 0 and 6 carry a timer input or its complemented output; the
    // timer's mode picks which, and its own driver enable tells us here.
    // the crystal claim wins over everything on pins 0 and 1.

    // crystal claims pins 0 and 1 whatever the port settings say
    // crystal override
    wire [7:0] xtal_mask = XTAL_ENABLE ? 8'h03 : 8'h00;
    wire [7:0] alt_a = enable_a & ~xtal_mask;

    // peripheral output values per pin, pin order 7..0
    // port a map
    wire [7:0] per_out_a = {TIMER_ONE_OUTPUT, TIMER_ONE_IN_OR_COMPLEMENT_OUT,
                            SERIAL_INFRARED_TRANSMIT, 1'b0, 1'b0,
                            SERIAL_DRIVER_ENABLE, TIMER_ZERO_OUTPUT,
                            TIMER_ZERO_IN_OR_COMPLEMENT_OUT};
    // pins 3 and 4 are pure inputs, so their driver stays off
    // peripheral driver enables: inputs drive nothing, outputs always drive
    // peripheral direction
    wire [7:0] per_oe_a = {1'b1, TIMER_ONE_IN_OR_COMPLEMENT_OE, 1'b1, 1'b0,
                           1'b0, 1'b1, 1'b1, TIMER_ZERO_IN_OR_COMPLEMENT_OE};

    wire [7:0] next_out_a = (alt_a & per_out_a) | (~alt_a & GPIO_OUT_A);
    // crystal pins are released from the digital driver
    wire [7:0] next_oe_a = ((alt_a & per_oe_a) | (~enable_a & ~dir_a)) & ~xtal_mask;

    ////////////////////////////////////////////////////////////////////////
    // port b routing
    //
    // set-one picks between two roles per pin, and only while enabled.
    // every role here is analog or an input, so no pin ever drives
    // digitally in alternate use. pins 6 and 7 offer only reserved roles;
    // enabling them is a software error and leaves them idle.

    wire [7:0] alt_b = cfg_b.enable;
    // analog on pins 0..5 with set-one high; 6 and 7 have none
    // port b analog
    wire [7:0] analog_b = alt_b & cfg_b.set_one & 8'h3F;
    // clock input on pin three with set-one low
    // clock pin
    wire clock_sel = alt_b[PAFM_CLOCK_PIN] & ~cfg_b.set_one[PAFM_CLOCK_PIN];
    // no port b function drives digitally; reserved choices leave driver off
    // reserved idle
    wire [7:0] next_oe_b = ~alt_b & ~cfg_b.dir;
    wire [7:0] next_out_b = ~alt_b & GPIO_OUT_B;

    ////////////////////////////////////////////////////////////////////////
    // port c routing
    //
    // set-one high gives led sinking on every pin, plus analog on 0..2.
    // set-one low is reserved except on pin 3, the comparator output.
    // the led is wired anode to supply, so lighting means driving low.

    wire [7:0] alt_c = cfg_c.enable;
    // analog on pins 0..2 with set-one high
    // port c analog
    wire [7:0] analog_c = alt_c & cfg_c.set_one & 8'h07;
    // led drive on all pins with set-one high
    // led and comparator
    wire [7:0] led_c = alt_c & cfg_c.set_one;
    wire comp_sel = alt_c[PAFM_COMPARATOR_PIN] & ~cfg_c.set_one[PAFM_COMPARATOR_PIN];
    wire [7:0] comp_mask = {4'h0, comp_sel, 3'h0};
    // led sinks current: drive low while lit
    wire [7:0] next_oe_c = (~alt_c & ~cfg_c.dir) | comp_mask | (led_c & LED_DRIVE_ON);
    wire [7:0] next_out_c = (~alt_c & GPIO_OUT_C) | (comp_mask & {8{COMPARATOR_RESULT_OUTPUT}});

    // status collects the two facts software checks before switching
    // the system clock over to the external pin
    // set-two contents never enter the routing above
    // set two ignored
    wire [7:0] status = {6'h00, clock_sel, XTAL_ENABLE};

    ////////////////////////////////////////////////////////////////////////
    // read mux: set-two registers read back as written
    // a plain decode; reads have no side effects, so a stray read strobe
    // is harmless

    logic [7:0] rd_mux;
    always_comb begin
        case (REG_ADDR)
            PAFM_OFS_A_DIR: rd_mux = dir_a;
            PAFM_OFS_A_ENABLE: rd_mux = enable_a;
            PAFM_OFS_B_DIR: rd_mux = cfg_b.dir;
            PAFM_OFS_B_ENABLE: rd_mux = cfg_b.enable;
            PAFM_OFS_B_SET_ONE: rd_mux = cfg_b.set_one;
            PAFM_OFS_B_SET_TWO: rd_mux = cfg_b.set_two;
            PAFM_OFS_C_DIR: rd_mux = cfg_c.dir;
            PAFM_OFS_C_ENABLE: rd_mux = cfg_c.enable;
            PAFM_OFS_C_SET_ONE: rd_mux = cfg_c.set_one;
            PAFM_OFS_C_SET_TWO: rd_mux = cfg_c.set_two;
            PAFM_OFS_STATUS: rd_mux = status;
            default: rd_mux = PAFM_RST_ZERO; // unmapped reads zero
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs: one cycle behind configuration
    // every pin-side signal leaves through a flop so pad timing does not
    // depend on decode depth. the cost is one cycle from a register write
    // to the pin, which software never sees because writes are posted.
    // a low clock enable freezes these flops with the configuration.

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= PAFM_RST_ZERO;
            PIN_OUT_A <= PAFM_RST_ZERO;
            PIN_OE_A <= PAFM_RST_ZERO;
            PIN_OUT_B <= PAFM_RST_ZERO;
            PIN_OE_B <= PAFM_RST_ZERO;
            PIN_OUT_C <= PAFM_RST_ZERO;
            PIN_OE_C <= PAFM_RST_ZERO;
            TIMER_ZERO_IN <= 1'b0;
            SERIAL_CLEAR_TO_SEND <= 1'b0;
            SERIAL_INFRARED_RECEIVE <= 1'b0;
            TIMER_ONE_IN <= 1'b0;
            EXTERNAL_CLOCK_INPUT <= 1'b0;
            ANALOG_CONNECT_B <= PAFM_RST_ZERO;
            ANALOG_CONNECT_C <= PAFM_RST_ZERO;
            LED_MODE_C <= PAFM_RST_ZERO;
            XTAL_PINS_TAKEN <= 1'b0;
        end else if (CE) begin
            // read data valid only in the cycle after the strobe
            REG_RDATA <= REG_RD ? rd_mux : PAFM_RST_ZERO;
            PIN_OUT_A <= next_out_a;
            PIN_OE_A <= next_oe_a;
            PIN_OUT_B <= next_out_b;
            PIN_OE_B <= next_oe_b;
            PIN_OUT_C <= next_out_c;
            PIN_OE_C <= next_oe_c;
            // inputs read as zero unless their pin is in alternate use
            TIMER_ZERO_IN <= alt_a[0] & sync2_a[0];
            SERIAL_CLEAR_TO_SEND <= alt_a[3] & sync2_a[3];
            SERIAL_INFRARED_RECEIVE <= alt_a[4] & sync2_a[4];
            TIMER_ONE_IN <= alt_a[6] & sync2_a[6];
            // clock is a sampled level here; the oscillator block takes it
            // clock source path
            EXTERNAL_CLOCK_INPUT <= clock_sel & sync2_b[PAFM_CLOCK_PIN];
            ANALOG_CONNECT_B <= analog_b;
            ANALOG_CONNECT_C <= analog_c;
            LED_MODE_C <= led_c;
            XTAL_PINS_TAKEN <= XTAL_ENABLE;
        end
    end

endmodule : pafm_mux

`default_nettype wire

// ---- testbench/pafm_mux_monitor.sv ----
// assertion checker for the alternate-function multiplexer
`timescale 1ns/1ps
`default_nettype none
module pafm_mux_monitor (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic XTAL_ENABLE,
    input wire logic [7:0] LED_DRIVE_ON,
    input wire logic [7:0] PIN_OE_A,
    input wire logic [7:0] PIN_OE_B,
    input wire logic [7:0] PIN_OE_C,
    input wire logic EXTERNAL_CLOCK_INPUT,
    input wire logic [7:0] ANALOG_CONNECT_B,
    input wire logic [7:0] ANALOG_CONNECT_C,
    input wire logic [7:0] LED_MODE_C,
    input wire logic XTAL_PINS_TAKEN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////
    chk_rdata_idle: assert property ($past(CE) && !$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_xtal_follow: assert property (!$past(RST) && $past(CE) |-> XTAL_PINS_TAKEN == $past(XTAL_ENABLE))
        else $error("crystal claim does not follow enable");
    chk_xtal_pins_off: assert property (XTAL_PINS_TAKEN |-> PIN_OE_A[1:0] == 2'b00)
        else $error("crystal pins still driven");
    chk_b_never_drives: assert property ((ANALOG_CONNECT_B & PIN_OE_B) == 8'h00)
        else $error("analog port b pin driven");
    chk_b_upper_reserved: assert property (ANALOG_CONNECT_B[7:6] == 2'b00)
        else $error("port b pins 6 7 connected");
    chk_c_analog_led: assert property (ANALOG_CONNECT_C == (LED_MODE_C & 8'h07))
        else $error("port c analog and led roles differ");
    chk_clock_vs_analog: assert property (EXTERNAL_CLOCK_INPUT |-> !ANALOG_CONNECT_B[3])
        else $error("clock input while pin three analog");
    chk_led_sink: assert property (LED_MODE_C[3] && $past(LED_MODE_C[3]) && $past(CE) |->
        PIN_OE_C[3] == $past(LED_DRIVE_ON[3])) else $error("led sink does not follow drive");
    // main scenarios reached
    cover property (XTAL_PINS_TAKEN);
    cover property (EXTERNAL_CLOCK_INPUT);
    cover property (LED_MODE_C[3] && PIN_OE_C[3]);
endmodule : pafm_mux_monitor
bind pafm_mux pafm_mux_monitor u_mon (.CLK(CLK), .RST(RST), .CE(CE), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .XTAL_ENABLE(XTAL_ENABLE), .LED_DRIVE_ON(LED_DRIVE_ON), .PIN_OE_A(PIN_OE_A), .PIN_OE_B(PIN_OE_B),
    .PIN_OE_C(PIN_OE_C), .EXTERNAL_CLOCK_INPUT(EXTERNAL_CLOCK_INPUT), .ANALOG_CONNECT_B(ANALOG_CONNECT_B),
    .ANALOG_CONNECT_C(ANALOG_CONNECT_C), .LED_MODE_C(LED_MODE_C), .XTAL_PINS_TAKEN(XTAL_PINS_TAKEN));
`default_nettype wire

// ---- testbench/test_pafm_mux.sv ----
// self-checking bench for the alternate-function multiplexer
`timescale 1ns/1ps
`default_nettype none
module test_pafm_mux
    import pafm_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr, rd, xtal, cmp_res, ext_clk, xtal_taken;
    logic ce = 1'b1;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, gout_a, led_on, pin_a, pin_b, drv, out_a, oe_a, out_b, oe_b, out_c, oe_c, an_b, an_c;
    logic [7:0] led_c;
    wire logic [3:0] ins; // peripheral inputs recovered from port a
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    pafm_mux uut (.CLK(clk), .RST(rst), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .GPIO_OUT_A(gout_a), .GPIO_OUT_B(gout_a), .GPIO_OUT_C(8'h00),
        .XTAL_ENABLE(xtal), .TIMER_ZERO_IN_OR_COMPLEMENT_OUT(drv[0]), .TIMER_ZERO_IN_OR_COMPLEMENT_OE(drv[1]),
        .TIMER_ZERO_OUTPUT(drv[2]), .SERIAL_DRIVER_ENABLE(drv[3]), .SERIAL_INFRARED_TRANSMIT(drv[4]),
        .TIMER_ONE_IN_OR_COMPLEMENT_OUT(drv[5]), .TIMER_ONE_IN_OR_COMPLEMENT_OE(drv[6]), .TIMER_ONE_OUTPUT(drv[7]),
        .COMPARATOR_RESULT_OUTPUT(cmp_res), .LED_DRIVE_ON(led_on), .PIN_IN_A(pin_a), .PIN_IN_B(pin_b),
        .PIN_OUT_A(out_a), .PIN_OE_A(oe_a), .PIN_OUT_B(out_b), .PIN_OE_B(oe_b), .PIN_OUT_C(out_c), .PIN_OE_C(oe_c),
        .TIMER_ZERO_IN(ins[0]), .SERIAL_CLEAR_TO_SEND(ins[1]), .SERIAL_INFRARED_RECEIVE(ins[2]),
        .TIMER_ONE_IN(ins[3]), .EXTERNAL_CLOCK_INPUT(ext_clk), .ANALOG_CONNECT_B(an_b),
        .ANALOG_CONNECT_C(an_c), .LED_MODE_C(led_c), .XTAL_PINS_TAKEN(xtal_taken));
    // 20 MHz clock
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // one-cycle write strobe
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // read data stand only in the cycle after the strobe
    task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(what, exp, rdata);
    endtask : rchk
    // outputs are registered one cycle behind the configuration
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////
    task automatic test_regs;
        for (int i = 0; i < 12; i++) begin
            rchk("reset value", i[3:0], (i == 0 || i == 2 || i == 6) ? PAFM_RST_DIR : PAFM_RST_ZERO);
        end
        wreg(PAFM_OFS_B_SET_TWO, 8'hA5);
        rchk("set two readback", PAFM_OFS_B_SET_TWO, 8'hA5);
        wreg(PAFM_OFS_STATUS, 8'hFF);
        rchk("status read only", PAFM_OFS_STATUS, 8'h00);
        wreg(4'hB, 8'hFF);
        rchk("unmapped index", 4'hB, 8'h00);
    endtask : test_regs
    // a write while the clock enable is low must not land
    task automatic test_freeze;
        @(posedge clk);
        ce <= 1'b0;
        wreg(PAFM_OFS_C_DIR, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        rchk("frozen c dir", PAFM_OFS_C_DIR, PAFM_RST_DIR);
    endtask : test_freeze
    task automatic test_port_a;
        wreg(PAFM_OFS_A_DIR, 8'h00);
        settle(2);
        cmp("a gpio oe", 8'hFF, oe_a);
        cmp("a gpio out", 8'h5A, out_a);
        wreg(PAFM_OFS_A_ENABLE, 8'hFF);
        drv <= 8'hB5;
        pin_a <= 8'h58;
        settle(4);
        cmp("a alt oe", 8'hA6, oe_a);
        cmp("a alt out", 8'hA2, out_a & 8'hA6);
        cmp("a pin inputs", 8'h0E, {4'h0, ins});
        @(posedge clk);
        drv <= 8'h4A;
        pin_a <= 8'hA7;
        settle(4);
        cmp("a alt oe", 8'hE7, oe_a);
        cmp("a alt out", 8'h04, out_a & 8'hE7);
        cmp("a pin inputs", 8'h01, {4'h0, ins});
    endtask : test_port_a
    task automatic test_xtal;
        @(posedge clk);
        xtal <= 1'b1;
        settle(2);
        cmp("xtal pins oe", 8'h00, oe_a & 8'h03);
        cmp("xtal taken", 8'h01, {7'h0, xtal_taken});
        rchk("status xtal", PAFM_OFS_STATUS, 8'h01);
        @(posedge clk);
        xtal <= 1'b0;
        settle(2);
        cmp("xtal released oe", 8'h03, oe_a & 8'h03);
    endtask : test_xtal
    task automatic test_port_b;
        wreg(PAFM_OFS_B_DIR, 8'h00);
        wreg(PAFM_OFS_B_SET_ONE, 8'hFF);
        settle(2);
        cmp("b analog no enable", 8'h00, an_b);
        cmp("b gpio oe", 8'hFF, oe_b);
        cmp("b gpio out", 8'h5A, out_b);
        // pins 6 and 7 offer no function, so software leaves them disabled
        wreg(PAFM_OFS_B_ENABLE, 8'h3F);
        settle(2);
        cmp("b analog", 8'h3F, an_b);
        cmp("b alt oe", 8'hC0, oe_b);
        cmp("b alt out", 8'h40, out_b);
        wreg(PAFM_OFS_B_SET_TWO, 8'h00);
        settle(2);
        cmp("b set two ignored", 8'h3F, an_b);
        wreg(PAFM_OFS_B_SET_ONE, 8'hF7);
        pin_b <= 8'h08;
        settle(4);
        cmp("b analog clock pin", 8'h37, an_b);
        cmp("b clock input", 8'h01, {7'h0, ext_clk});
        rchk("status clock", PAFM_OFS_STATUS, 8'h02);
        @(posedge clk);
        pin_b <= 8'hF7;
        settle(4);
        cmp("b clock low", 8'h00, {7'h0, ext_clk});
    endtask : test_port_b
    task automatic test_port_c;
        wreg(PAFM_OFS_C_ENABLE, 8'hFF);
        wreg(PAFM_OFS_C_SET_ONE, 8'hFF);
        led_on <= 8'h08;
        settle(2);
        cmp("c led mode", 8'hFF, led_c);
        cmp("c analog", 8'h07, an_c);
        cmp("c led sink oe", 8'h08, oe_c);
        cmp("c led sink out", 8'h00, out_c & 8'h08);
        wreg(PAFM_OFS_C_SET_ONE, 8'h00);
        cmp_res <= 1'b1;
        settle(2);
        cmp("c comparator oe", 8'h08, oe_c);
        cmp("c comparator out", 8'h08, out_c & 8'h08);
        cmp("c reserved", 8'h00, led_c | an_c);
    endtask : test_port_c
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        {wr, rd, xtal, cmp_res} = 4'h0;
        {addr, wdata, led_on, pin_a, pin_b, drv} = '0;
        gout_a = 8'h5A;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_freeze();
        test_port_a();
        test_xtal();
        test_port_b();
        test_port_c();
        complete_run();
    end
endmodule : test_pafm_mux
`default_nettype wire
